// ### rtl/rsb_pkg.sv
// Shared constants and types of the radio setup register bank
package rsb_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [4:0] ADDR_WIDTH_SETUP = 5'h03; // Address width
  localparam logic [4:0] RETRANSMIT_SETUP = 5'h04; // Retry setup
  localparam logic [4:0] RADIO_CHANNEL    = 5'h05; // Channel
  localparam logic [4:0] RADIO_SETUP      = 5'h06; // Radio_setup

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int WIDTH_LSB   = 0; // Address width code 1:0
  localparam int DELAY_LSB   = 4; // Retry delay 7:4
  localparam int COUNT_LSB   = 0; // Retry count 3:0
  localparam int CHAN_LSB    = 0; // Channel 6:0
  localparam int CARRIER_BIT = 7; // Continuous carrier
  localparam int LOW_BIT     = 5; // Low rate select
  localparam int LOCK_BIT    = 4; // Forced lock
  localparam int HIGH_BIT    = 3; // High rate select
  localparam int POWER_LSB   = 1; // Output power 2:1

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [1:0] WIDTH_RESET   = 2'h3;
  localparam logic [3:0] DELAY_RESET   = 4'h0;
  localparam logic [3:0] COUNT_RESET   = 4'h3;
  localparam logic [6:0] CHAN_RESET    = 7'h02;
  localparam logic       CARRIER_RESET = 1'h0;
  localparam logic       LOW_RESET     = 1'h0;
  localparam logic       LOCK_RESET    = 1'h0;
  localparam logic       HIGH_RESET    = 1'h1;
  localparam logic [1:0] POWER_RESET   = 2'h3;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLOCK_KHZ     = 10000; // 10 MHz core clock
  localparam int DELAY_STEP_US = 250;   // Retry delay step
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLOCK_KHZ / 1000;

  // ==========================================================
  // Types
  // ==========================================================
  // Decoded air data rate
  typedef enum logic [1:0] {RATE_1M, RATE_2M, RATE_250K} rsb_rate_e;

  // Settings handed to the radio core
  typedef struct packed {
    logic [2:0]  addrBytes;         // Address width in bytes
    logic [4:0]  addrByteMask;      // Used address bytes, LSByte first
    logic        addrWidthIllegal;  // Code 00 stored
    logic [15:0] retryDelayCycles;  // Wait between transmissions
    logic [3:0]  retryCount;        // Retries allowed
    logic        retryEnable;       // Retries on at all
    logic [6:0]  channel;           // Frequency channel
    logic        continuousCarrier; // Carrier test transmit
    rsb_rate_e   dataRate;          // Air data rate
    logic        rateReserved;      // Pair 11 stored
    logic        forceLock;         // Test: force lock indication
    logic [1:0]  outputPower;       // 00 -18, 01 -12, 10 -6, 11 0 dBm
  } rsb_settings_s;

endpackage : rsb_pkg

// ### rtl/rsb_register_bank.sv
// Radio setup register bank: storage, readback and decoded settings
// What this block does
// - Two-bit address width code, reset 11.
// - Short addresses use low bytes only.
// - One width for all pipes; upper zero.
// - Retry delay 7:4, 250 us steps.
// - Retry count 3:0, reset 3, 0 off.
// - Seven-bit channel, reset 2, bit7 reserved.
// - Bit 7 enables continuous carrier transmit.
// - Low/high rate bits pick data rate.
// - Low rate set overrides high rate.
// - Bit 4 forces lock, test only.
// - Output power code 2:1, reset 11.
// - Registers reached by read/write commands.
// - Undefined bits read back as zero.
`timescale 1ns/1ps
`default_nettype none

module rsb_register_bank #(
  parameter int DELAY_STEP_CYCLES = rsb_pkg::DELAY_STEP_CYCLES
) (
  input  wire logic               clock,     // 10 MHz core clock
  input  wire logic               rst_b,     // Async reset, active low
  input  wire logic [4:0]         regAddr,   // Register address
  input  wire logic               regWrite,  // Write command strobe
  input  wire logic               regRead,   // Read command strobe
  input  wire logic [7:0]         regWdata,  // Write data
  output logic      [7:0]         regRdata,  // Read data
  output logic                    regRvalid, // Read data valid pulse
  output rsb_pkg::rsb_settings_s  settings   // Decoded settings
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rstMeta; // First release stage
  logic rstN;    // Released reset for the design

  // Two-stage release of the async reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ==========================================================
  // Functions
  // ==========================================================
  // Width code to byte count; illegal code treated as five
  function automatic logic [2:0] width_bytes(input logic [1:0] code);
    unique case (code)
      2'h1:    width_bytes = 3'h3;
      2'h2:    width_bytes = 3'h4;
      default: width_bytes = 3'h5;
    endcase
  endfunction : width_bytes

  // Mask of address bytes in use, least significant first
  function automatic logic [4:0] byte_mask(input logic [1:0] code);
    unique case (code)
      2'h1:    byte_mask = 5'h07;
      2'h2:    byte_mask = 5'h0f;
      default: byte_mask = 5'h1f;
    endcase
  endfunction : byte_mask

  // Rate pair to rate; low select wins over high
  function automatic rsb_pkg::rsb_rate_e rate_of(input logic low,
                                                 input logic high);
    if (low)
      rate_of = rsb_pkg::RATE_250K;
    else if (high)
      rate_of = rsb_pkg::RATE_2M;
    else
      rate_of = rsb_pkg::RATE_1M;
  endfunction : rate_of

  // Delay code to cycle count
  function automatic logic [15:0] delay_cycles(input logic [3:0] code);
    delay_cycles = 16'((32'(code) + 32'd1) * DELAY_STEP_CYCLES);
  endfunction : delay_cycles

  // ==========================================================
  // Storage
  // ==========================================================
  logic [1:0] widthCode; // Address width code
  logic [3:0] delay;    // Retry delay code
  logic [3:0] count;    // Retry count code
  logic [6:0] channel;  // Channel number
  logic       carrier;  // Continuous carrier
  logic       lowRate;  // Low rate select
  logic       lock;     // Forced lock
  logic       highRate; // High rate select
  logic [1:0] power;    // Output power code

  // Write strobes per register
  logic wrWidth, wrRetry, wrChan, wrSetup;
  assign wrWidth = regWrite && (regAddr == rsb_pkg::ADDR_WIDTH_SETUP);
  assign wrRetry = regWrite && (regAddr == rsb_pkg::RETRANSMIT_SETUP);
  assign wrChan  = regWrite && (regAddr == rsb_pkg::RADIO_CHANNEL);
  assign wrSetup = regWrite && (regAddr == rsb_pkg::RADIO_SETUP);

  // Address width register, upper bits not stored
  // width code storage
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN)
      widthCode <= rsb_pkg::WIDTH_RESET;
    else if (wrWidth)
      widthCode <= regWdata[rsb_pkg::WIDTH_LSB +: 2];
  end

  // Retry setup register
  // delay field storage
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      delay <= rsb_pkg::DELAY_RESET;
      count <= rsb_pkg::COUNT_RESET;
    end else if (wrRetry) begin
      delay <= regWdata[rsb_pkg::DELAY_LSB +: 4];
      count <= regWdata[rsb_pkg::COUNT_LSB +: 4];
    end
  end

  // Channel register, reserved bit 7 not stored
  // channel storage
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN)
      channel <= rsb_pkg::CHAN_RESET;
    else if (wrChan)
      channel <= regWdata[rsb_pkg::CHAN_LSB +: 7];
  end

  // Radio_setup register, reserved bits 6 and 0 not stored
  // carrier bit
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      carrier  <= rsb_pkg::CARRIER_RESET;
      lowRate  <= rsb_pkg::LOW_RESET;
      lock     <= rsb_pkg::LOCK_RESET;
      highRate <= rsb_pkg::HIGH_RESET;
      power    <= rsb_pkg::POWER_RESET;
    end else if (wrSetup) begin
      carrier  <= regWdata[rsb_pkg::CARRIER_BIT];
      lowRate  <= regWdata[rsb_pkg::LOW_BIT];
      lock     <= regWdata[rsb_pkg::LOCK_BIT];
      highRate <= regWdata[rsb_pkg::HIGH_BIT];
      power    <= regWdata[rsb_pkg::POWER_LSB +: 2];
    end
  end

  // ==========================================================
  // Readback
  // ==========================================================
  logic [7:0] readWord; // Selected register image

  // Image of the addressed register, undefined bits zero
  // zero fill
  always_comb begin
    readWord = 8'h00;
    unique case (regAddr)
      rsb_pkg::ADDR_WIDTH_SETUP: readWord[rsb_pkg::WIDTH_LSB +: 2] = widthCode;
      rsb_pkg::RETRANSMIT_SETUP: readWord = {delay, count};
      rsb_pkg::RADIO_CHANNEL:    readWord[rsb_pkg::CHAN_LSB +: 7] = channel;
      rsb_pkg::RADIO_SETUP: begin
        readWord[rsb_pkg::CARRIER_BIT]     = carrier;
        readWord[rsb_pkg::LOW_BIT]         = lowRate;
        readWord[rsb_pkg::LOCK_BIT]        = lock;
        readWord[rsb_pkg::HIGH_BIT]        = highRate;
        readWord[rsb_pkg::POWER_LSB +: 2]  = power;
      end
      default:                   readWord = 8'h00; // Unmapped
    endcase
  end

  // Read answer one cycle after the command
  // read command
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      regRdata  <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead)
        regRdata <= readWord;
    end
  end

  // ==========================================================
  // Decoded settings
  // ==========================================================
  // Registered decode for the radio core
  // low address bytes
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      settings <= '0;
    end else begin
      settings.addrBytes         <= width_bytes(widthCode);
      settings.addrByteMask      <= byte_mask(widthCode);
      settings.addrWidthIllegal  <= (widthCode == 2'h0);
      settings.retryDelayCycles  <= delay_cycles(delay);
      settings.retryCount        <= count;
      settings.retryEnable       <= (count != 4'h0);
      settings.channel           <= channel;
      settings.continuousCarrier <= carrier;
      settings.dataRate          <= rate_of(lowRate, highRate);
      settings.rateReserved      <= lowRate && highRate;
      settings.forceLock         <= lock;
      settings.outputPower       <= power;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  // Write then read of one register
  sequence s_write(logic [4:0] a);
    regWrite && !regRead && regAddr == a;
  endsequence
  sequence s_read(logic [4:0] a);
    regRead && !regWrite && regAddr == a;
  endsequence

  a_width_readback: assert property (
    s_write(rsb_pkg::ADDR_WIDTH_SETUP) ##1 s_read(rsb_pkg::ADDR_WIDTH_SETUP)
    |=> regRvalid && regRdata == {6'h00, $past(regWdata[1:0], 2)})
    else $error("width readback wrong");

  a_width_upper_zero: assert property (
    regRead && regAddr == rsb_pkg::ADDR_WIDTH_SETUP
    |=> regRdata[7:2] == 6'h00)
    else $error("width upper bits not zero");

  a_mask_width: assert property (
    settings.addrByteMask == 5'((6'h01 << settings.addrBytes) - 6'h01))
    else $error("byte mask mismatch");

  a_delay_steps: assert property (
    s_write(rsb_pkg::RETRANSMIT_SETUP) |-> ##2
    settings.retryDelayCycles ==
      16'((32'($past(regWdata[7:4], 2)) + 32'd1) * DELAY_STEP_CYCLES))
    else $error("retry delay wrong");

  a_count_enable: assert property (
    s_write(rsb_pkg::RETRANSMIT_SETUP) |-> ##2
    settings.retryEnable == ($past(regWdata[3:0], 2) != 4'h0)
    && settings.retryCount == $past(regWdata[3:0], 2))
    else $error("retry count wrong");

  a_chan_reserved: assert property (
    regRead && regAddr == rsb_pkg::RADIO_CHANNEL
    |=> regRdata[7] == 1'b0 && regRdata[6:0] == settings.channel)
    else $error("channel readback wrong");

  a_carrier_follow: assert property (
    s_write(rsb_pkg::RADIO_SETUP) |-> ##2
    settings.continuousCarrier == $past(regWdata[7], 2)
    && settings.forceLock == $past(regWdata[4], 2))
    else $error("carrier or lock wrong");

  a_rate_low_wins: assert property (
    s_write(rsb_pkg::RADIO_SETUP) ##0 regWdata[5] |-> ##2
    settings.dataRate == rsb_pkg::RATE_250K)
    else $error("low rate not decoded");

  a_rate_high: assert property (
    s_write(rsb_pkg::RADIO_SETUP) ##0 !regWdata[5] |-> ##2
    settings.dataRate ==
      ($past(regWdata[3], 2) ? rsb_pkg::RATE_2M : rsb_pkg::RATE_1M))
    else $error("high rate decode wrong");

  a_power_code: assert property (
    s_write(rsb_pkg::RADIO_SETUP) |-> ##2
    settings.outputPower == $past(regWdata[2:1], 2))
    else $error("power code wrong");

  a_unmapped_zero: assert property (
    regRead && (regAddr < rsb_pkg::ADDR_WIDTH_SETUP
                || regAddr > rsb_pkg::RADIO_SETUP)
    |=> regRvalid && regRdata == 8'h00)
    else $error("unmapped read not zero");

  // Illegal width flag follows the stored code
  a_width_illegal: assert property (
    s_write(rsb_pkg::ADDR_WIDTH_SETUP) |-> ##2
    settings.addrWidthIllegal == ($past(regWdata[1:0], 2) == 2'h0))
    else $error("width illegal flag wrong");

  // Reserved rate pair is flagged for the radio core
  a_rate_reserved: assert property (
    s_write(rsb_pkg::RADIO_SETUP) |-> ##2
    settings.rateReserved ==
      ($past(regWdata[5], 2) && $past(regWdata[3], 2)))
    else $error("rate reserved flag wrong");

  // Read answer comes exactly one cycle after each read
  a_valid_pulse: assert property (
    regRvalid == $past(regRead))
    else $error("read valid pulse wrong");

endmodule : rsb_register_bank

`default_nettype wire

// ### tb/rsb_ctrl_model.sv
// Controller model issuing register read and write commands
`timescale 1ns/1ps
`default_nettype none

module rsb_ctrl_model (
  input  wire logic       clock,    // Core clock
  output var  logic [4:0] regAddr,  // Command address
  output var  logic       regWrite, // Write strobe
  output var  logic       regRead,  // Read strobe
  output var  logic [7:0] regWdata  // Write data
);
  // ==========================================================
  // Command driver
  // ==========================================================
  // Idle at time zero, no strobe before reset release
  initial begin
    regAddr  = 5'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regWdata = 8'h00;
  end

  // reserved codes only when the bench passes them
  task automatic cmd(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWrite <= wr;
    regRead  <= !wr;
    regWdata <= d;
    @(posedge clock);
    // Released lines show the inverse, not a stale value
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask : cmd

  // Write, then read the same place on the very next edge
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWrite <= 1'b1;
    regRead  <= 1'b0;
    regWdata <= d;
    @(posedge clock);
    // Write taken, read follows back to back
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    regWdata <= ~d;
    @(posedge clock);
    regRead  <= 1'b0;
    regAddr  <= ~a;
  endtask : wr_rd
endmodule : rsb_ctrl_model

`default_nettype wire

// ### tb/radio_setup_register_bank_tb.sv
// Self-checking bench of the radio setup register bank
`timescale 1ns/1ps
`default_nettype none

module radio_setup_register_bank_tb;
  localparam int STEP = 4;          // Short delay step for simulation
  logic          clock = 1'b0;      // Core clock
  logic          rst_b = 1'b0;      // Reset, active low
  wire logic [4:0] regAddr;         // From controller model
  wire logic     regWrite;          // From controller model
  wire logic     regRead;           // From controller model
  wire logic [7:0] regWdata;        // From controller model
  logic [7:0]    regRdata;          // Read data
  logic          regRvalid;         // Read data valid
  rsb_pkg::rsb_settings_s settings; // Decoded settings
  logic [7:0]    expQ[$];           // Expected read values
  logic [7:0]    v;                 // Stimulus byte
  int            n_errors = 0;      // Mismatches
  int            tests_run = 0;     // Comparisons
  int            seed;              // Seed result

  always #50 clock = ~clock;

  rsb_register_bank #(.DELAY_STEP_CYCLES(STEP)) u_rsb_register_bank (
    .clock(clock), .rst_b(rst_b), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .settings(settings));

  rsb_ctrl_model u_rsb_ctrl_model (
    .clock(clock), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata));

  // ==========================================================
  // Helpers
  // ==========================================================
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write, then wait for settings to follow
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_rsb_ctrl_model.cmd(1'b1, a, d);
    repeat (2) @(posedge clock);
    #1;
  endtask : wr

  // Read, noting the expected byte first
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    expQ.push_back(e);
    u_rsb_ctrl_model.cmd(1'b0, a, 8'h00);
  endtask : rd

  // Verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Read monitor
  // ==========================================================
  // Each valid cycle takes the oldest note
  always @(negedge clock) begin
    if (regRvalid === 1'b1) begin
      if (expQ.size() == 0) chk(1, 0);
      else chk(regRdata, expQ.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    $display("wrong value at %0t: run limit used up", $time);
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = $urandom(32'hd681);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    // Reset values, decoded and read back
    chk(settings.addrBytes, 5);
    chk(settings.addrByteMask, 32'h1f);
    chk(settings.retryDelayCycles, STEP);
    chk({settings.retryEnable, settings.retryCount}, 5'h13);
    chk(settings.channel, 2);
    chk(settings.dataRate, rsb_pkg::RATE_2M);
    chk({settings.continuousCarrier, settings.forceLock}, 0);
    chk(settings.outputPower, 3);
    chk({settings.addrWidthIllegal, settings.rateReserved}, 0);
    rd(5'h03, 8'h03);
    rd(5'h04, 8'h03);
    rd(5'h05, 8'h02);
    rd(5'h06, 8'h0e);
    // Width codes with upper bits set on purpose
    for (int c = 1; c < 4; c++) begin
      expQ.push_back(8'(c));
      u_rsb_ctrl_model.wr_rd(5'h03, 8'hfc | 8'(c));
      repeat (2) @(posedge clock);
      #1;
      chk(settings.addrBytes, c + 2);
      chk(settings.addrWidthIllegal, 0);
      chk(settings.addrByteMask, (1 << (c + 2)) - 1);
    end
    // Retry boundaries and one random byte
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hf0 : 8'($urandom);
      wr(5'h04, v);
      chk(settings.retryDelayCycles, (v[7:4] + 1) * STEP);
      chk(settings.retryCount, v[3:0]);
      chk(settings.retryEnable, v[3:0] != 4'h0);
      rd(5'h04, v);
    end
    // Channel with reserved top bit set
    v = 8'($urandom) | 8'h80;
    wr(5'h05, v);
    chk(settings.channel, v[6:0]);
    rd(5'h05, {1'b0, v[6:0]});
    // Every rate pair, random other fields
    for (int p = 0; p < 4; p++) begin
      v = 8'($urandom);
      v[5] = p[1];
      v[3] = p[0];
      wr(5'h06, v);
      chk(settings.dataRate, (p == 0) ? rsb_pkg::RATE_1M : (p == 1) ?
          rsb_pkg::RATE_2M : rsb_pkg::RATE_250K);
      chk(settings.continuousCarrier, v[7]);
      chk(settings.forceLock, v[4]);
      chk(settings.outputPower, v[2:1]);
      chk(settings.rateReserved, p == 3);
      rd(5'h06, v & 8'hbe);
    end
    // Unmapped place: write ignored, reads zero
    wr(5'h07, 8'hff);
    rd(5'h07, 8'h00);
    rd(5'h1f, 8'h00);
    rd(5'h03, 8'h03);
    // Drain outstanding reads
    for (int k = 0; k < 20 && expQ.size() != 0; k++) @(posedge clock);
    if (expQ.size() != 0) begin
      n_errors++;
      $display("wrong value at %0t: reads left unanswered", $time);
    end
    end_of_test();
  end
endmodule : radio_setup_register_bank_tb

`default_nettype wire
